//--- bench/sysctl_wake_watchdog_regs_bench.sv
`timescale 1ns/100ps
module sysctl_wake_watchdog_regs_bench
    import swwr_pkg::*;
;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;  // Clock, reset, APB control
    logic        wd_near_overflow = 0, wd_overflow = 0, reset_pin_high = 0;  // Watchdog events
    logic [15:0] paddr = '0;                                                 // Byte address
    logic [31:0] pwdata = '0, prdata, rd;                                    // Bus data, last read
    logic [3:0]  pstrb = STRB_BYTE0;                                         // Byte lane 0 only
    logic [7:0]  trim = 8'hA7, boot_kb = 8'h01, base_kb = 8'h02;             // Fuse and region sizes
    logic [7:0]  fuse_readout, unlock_val;                                   // Readouts
    swwr_mode_s  mode = '0;                                                  // Power mode levels
    swwr_erase_s erase = '0;                                                 // Erase request
    logic        pready, pslverr, pad_en, ref_dis, restart, unlock, wake, grant, refused, er;
    int          err_total = 0, compares = 0;                                // Report counters
    // Clock of 20 ns period
    always #10 pclk = ~pclk;
    // Device with a short wake unit
    swwr_regs #(.UNIT_CYC(20), .REVISION(8'h3C)) i_dut (
        .pclk(pclk), .presetn(presetn), .nv_rstn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode(mode), .wd_near_overflow(wd_near_overflow),
        .wd_overflow(wd_overflow), .reset_pin_high(reset_pin_high), .reference_magnitude_trim(trim),
        .erase(erase), .boot_size_kb(boot_kb), .compute_code_base_kb(base_kb), .fuse_readout(fuse_readout),
        .vref_pad_en(pad_en), .vref_disable(ref_dis), .wd_restart(restart), .rtc_unlock(unlock),
        .rtc_unlock_value(unlock_val), .wake_req(wake), .erase_grant(grant), .erase_refused(refused));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Compare one value, count and report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx[13:0], 2'b00};
        pwdata  <= d;
        tick(1);
        penable <= 1'b1;
        do begin
            tick(1);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle cycle, so a following call never drives psel twice in one step
        tick(1);
        if (n >= 20) begin
            err_total++;
            stop_test();
        end
    endtask : apb
    task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, '0);
        chk(name, exp, rd);
    endtask : rdchk
    // Erase attempt; refusal and grant are one-cycle pulses
    task automatic try_erase(input logic [17:0] a, input logic exp_ref, input string name);
        erase <= '{1'b1, a};
        tick(1);
        erase.req <= 1'b0;
        tick(1);
        chk(name, {30'h0, exp_ref, ~exp_ref}, {30'h0, refused, grant});
    endtask : try_erase
    // Arm with the old setting, rewrite period, sleep and time the wake
    task automatic autowake(input logic [31:0] cfg, input int lo, input int hi, input string name);
        int n;
        n = 0;
        apb(1'b1, IDX_AUTOWAKE, cfg);
        apb(1'b1, IDX_AUTOWAKE, 32'h81);
        rdchk("arm reads zero", IDX_AUTOWAKE, 32'h01);
        mode.sleep <= 1'b1;
        do begin
            tick(1);
            n++;
        end while (wake !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            err_total++;
            stop_test();
        end
        chk(name, 32'h1, {31'h0, n >= lo && n <= hi});
        mode <= '{1'b1, 1'b0, 1'b0, 1'b0};
        tick(2);
        chk("wake drops", 32'h0, {31'h0, wake});
        mode <= '0;
        tick(1);
    endtask : autowake
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset value, revision and bus error
    task automatic regs_basic;
        rdchk("period reset", IDX_AUTOWAKE, 32'h01);
        rdchk("revision", IDX_REVISION, 32'h3C);
        apb(1'b1, IDX_REVISION2, 32'hFF);
        rdchk("revision alt", IDX_REVISION2, 32'h3C);
        apb(1'b0, 16'h0100, '0);
        chk("unmapped error", 32'h1, {31'h0, er});
    endtask : regs_basic
    // Trim select 1 shows the reference fuse; disable bit blocks pad routing
    task automatic trim_vref;
        apb(1'b1, IDX_TRIM_SEL, 32'h1);
        tick(2);
        chk("fuse sel 1", {24'h0, trim}, {24'h0, fuse_readout});
        apb(1'b1, IDX_TRIM_SEL, 32'h2);
        tick(2);
        chk("fuse sel 2", 32'h0, {24'h0, fuse_readout});
        apb(1'b1, IDX_VREF_CTRL, 32'h80);
        tick(2);
        chk("pad on", 32'h1, {31'h0, pad_en});
        apb(1'b1, IDX_VREF_CTRL, 32'h88);
        tick(2);
        chk("pad off", 32'h2, {30'h0, ref_dis, pad_en});
    endtask : trim_vref
    // Kick needs all ones; strobes stand one cycle, right after the transfer
    task automatic kick_unlock;
        apb(1'b1, IDX_WD_KICK, 32'h7F);
        chk("no restart", 32'h0, {31'h0, restart});
        apb(1'b1, IDX_WD_KICK, 32'hFF);
        chk("restart", 32'h1, {31'h0, restart});
        apb(1'b1, IDX_RTC_UNLOCK, 32'h5C);
        chk("unlock pulse", 32'h1, {31'h0, unlock});
        tick(2);
        chk("unlock value", 32'h5C, {24'h0, unlock_val});
    endtask : kick_unlock
    // Expired status and near flag
    task automatic status_flags;
        wd_overflow <= 1'b1;
        tick(1);
        wd_overflow <= 1'b0;
        rdchk("expired set", IDX_WD_STATUS, 32'h4);
        reset_pin_high <= 1'b1;
        tick(2);
        reset_pin_high <= 1'b0;
        rdchk("expired clear", IDX_WD_STATUS, 32'h0);
        wd_near_overflow <= 1'b1;
        tick(1);
        wd_near_overflow <= 1'b0;
        rdchk("near set", IDX_NEAR_FLAG, 32'h1);
        apb(1'b1, IDX_NEAR_FLAG, 32'h0);
        rdchk("near clear", IDX_NEAR_FLAG, 32'h0);
    endtask : status_flags
    // Erase locks at the region boundaries
    task automatic erase_locks;
        apb(1'b1, IDX_ERASE_LOCK, 32'h30);
        try_erase(18'd1023, 1'b1, "boot top");
        try_erase(18'd1024, 1'b0, "boot above");
        try_erase(18'd2047, 1'b0, "code below");
        try_erase(18'd2048, 1'b1, "code base");
        apb(1'b1, IDX_ERASE_LOCK, 32'h0);
        try_erase(18'd0, 1'b0, "unlocked");
    endtask : erase_locks
    initial begin
        tick(2);
        presetn <= 1'b1;
        tick(1);
        regs_basic();
        trim_vref();
        kick_unlock();
        status_flags();
        erase_locks();
        // Two units of 2.5 s, then one minute unit of 24 short units
        autowake(32'h02, 38, 50, "wake short");
        autowake(32'h09, 480, 490, "wake minute");
        stop_test();
    end
endmodule : sysctl_wake_watchdog_regs_bench

//--- hdl/swwr_regs.sv
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
// What this block does
// [RL1] Select 1 shows reference magnitude trim fuse
// [RL2] Read-only revision index at two locations
// [RL3] Reference to pad unless reference disabled
// [RL4] Arm write loads timer from the stored period and resolution
// [RL5] Full power or brownout resets, disarms timer
// [RL6] Firmware arms three clock cycles before sleep
// [RL7] Duration is period times unit, resets 001
// [RL8] Resolution 1 minute, else 2.5 seconds
// [RL9] Near flag set early, cleared write/wake fall
// [RL10] Byte write of FF restarts watchdog
// [RL11] Expired bit set on overflow, nonvolatile
// [RL12] Expired bit cleared while reset pin high
// [RL13] Firmware writes unlock before clock registers
// [RL14] Boot lock refuses erase below boot size
// [RL15] Code lock refuses erase from base upward
// [RL16] Expired armed timer raises wake request
module swwr_regs
    import swwr_pkg::*;
#(
    parameter int          UNIT_CYC = WAKE_UNIT_CYC,   // Cycles per 2.5 s unit
    parameter logic [7:0]  REVISION = REVISION_DEFAULT // Arbitrary value
) (
    // Clock and resets
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        nv_rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Power modes and watchdog events
    input  wire swwr_mode_s  mode,
    input  wire logic        wd_near_overflow,
    input  wire logic        wd_overflow,
    input  wire logic        reset_pin_high,
    // Trim fuse
    input  wire logic [7:0]  reference_magnitude_trim,
    // Flash erase check
    input  wire swwr_erase_s erase,
    input  wire logic [7:0]  boot_size_kb,
    input  wire logic [7:0]  compute_code_base_kb,
    // Outputs
    output logic      [7:0]  fuse_readout,
    output logic             vref_pad_en,
    output logic             vref_disable,
    output logic             wd_restart,
    output logic             rtc_unlock,
    output logic      [7:0]  rtc_unlock_value,
    output logic             wake_req,
    output logic             erase_grant,
    output logic             erase_refused
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic        pready_r;          // Access-phase ready
    logic        pslverr_r;         // Unmapped address error
    logic [31:0] prdata_r;          // Read data
    logic        boot_lock_r;       // Boot region erase lock
    logic        code_lock_r;       // Code region erase lock
    logic        expired_r;         // Watchdog expired status
    logic        ref_pad_r;         // Reference to pad request
    logic        ref_dis_r;         // Reference disable
    logic [2:0]  period_r;          // Sleep period
    logic        res_r;             // Sleep resolution
    logic        near_r;            // Near-expiry flag
    logic [3:0]  trim_sel_r;        // Trim fuse select
    logic [7:0]  fuse_r;            // Fuse readout
    logic        vref_pad_r;        // Pad routing output
    logic        wd_restart_r;      // Watchdog restart pulse
    logic        rtc_unlock_r;      // Unlock pulse
    logic [7:0]  rtc_val_r;         // Unlock value
    logic        wake_r;            // Wake request
    logic        wake_d_r;          // Wake delayed for edge
    logic        grant_r;           // Erase granted pulse
    logic        refused_r;         // Erase refused pulse
    logic        hp_d_r;            // High-power mode delayed
    logic [26:0] pre_r;             // Unit prescaler
    logic [7:0]  remain_r;          // Units left
    swwr_aw_e    aw_r;              // Autowake state
    logic        acc_done;          // Transfer completes this edge
    logic        wr_en;             // Byte-0 write completes
    logic        hp;                // Full power or brownout
    logic        lp;                // Sleep or display-only
    logic        arm_wr;            // Arm write
    logic        unit_tick;         // One 2.5 s unit elapsed
    logic        mapped;            // Address decodes
    logic [31:0] rd_nxt;            // Read mux
    logic [7:0]  load_nxt;          // Loaded sleep units
    logic        boot_hit;          // Address in boot region
    logic        code_hit;          // Address in code region
    logic [9:0]  p24;               // Period scaled to minutes

    assign acc_done  = psel & penable & pready_r;
    assign wr_en     = acc_done & pwrite & pstrb[0];
    assign hp        = mode.full_power | mode.brownout;
    assign lp        = mode.sleep | mode.display_only;
    assign arm_wr    = wr_en & (paddr[15:2] == IDX_AUTOWAKE[13:0]) & pwdata[BIT_ARM];
    assign unit_tick = (pre_r == 27'(UNIT_CYC - 1));
    // Duration in 2.5 s units: period times 1 or 24
    assign p24       = {7'h00, period_r} * {2'b00, MINUTE_TICKS};
    assign load_nxt  = res_r ? p24[7:0] : {5'h00, period_r}; // [RL7] [RL8]
    assign boot_hit  = erase.addr < {boot_size_kb, 10'h000};
    assign code_hit  = erase.addr >= {compute_code_base_kb, 10'h000};

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Read mux and address check
    always_comb begin
        rd_nxt = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (paddr[15:2] == IDX_ERASE_LOCK[13:0]) begin
            rd_nxt[BIT_BOOT_LOCK] = boot_lock_r;
            rd_nxt[BIT_CODE_LOCK] = code_lock_r;
        end else if (paddr[15:2] == IDX_WD_KICK[13:0]) begin
            rd_nxt = 32'h0000_0000;
        end else if (paddr[15:2] == IDX_WD_STATUS[13:0]) begin
            rd_nxt[BIT_EXPIRED] = expired_r;
        end else if (paddr[15:2] == IDX_VREF_CTRL[13:0]) begin
            rd_nxt[BIT_REF_PAD] = ref_pad_r;
            rd_nxt[BIT_REF_DIS] = ref_dis_r;
        end else if (paddr[15:2] == IDX_REVISION[13:0]) begin
            rd_nxt[7:0] = REVISION;                       // [RL2]
        end else if (paddr[15:2] == IDX_REVISION2[13:0]) begin
            rd_nxt[7:0] = REVISION;                       // [RL2]
        end else if (paddr[15:2] == IDX_RTC_UNLOCK[13:0]) begin
            rd_nxt = 32'h0000_0000;
        end else if (paddr[15:2] == IDX_AUTOWAKE[13:0]) begin
            rd_nxt[BIT_RES] = res_r;
            rd_nxt[2:0]     = period_r;
        end else if (paddr[15:2] == IDX_NEAR_FLAG[13:0]) begin
            rd_nxt[BIT_NEAR] = near_r;
        end else if (paddr[15:2] == IDX_TRIM_SEL[13:0]) begin
            rd_nxt[3:0] = trim_sel_r;
        end else begin
            mapped = 1'b0;
        end
    end

    // One wait state, then answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (psel & penable & !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Software fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_lock_r <= 1'b0;
            code_lock_r <= 1'b0;
            ref_pad_r   <= 1'b0;
            ref_dis_r   <= 1'b0;
            period_r    <= PERIOD_RESET;                  // [RL7]
            res_r       <= 1'b0;
            trim_sel_r  <= TRIM_SEL_RESET;
        end else if (wr_en) begin
            if (paddr[15:2] == IDX_ERASE_LOCK[13:0]) begin
                boot_lock_r <= pwdata[BIT_BOOT_LOCK];
                code_lock_r <= pwdata[BIT_CODE_LOCK];
            end else if (paddr[15:2] == IDX_VREF_CTRL[13:0]) begin
                ref_pad_r <= pwdata[BIT_REF_PAD];
                ref_dis_r <= pwdata[BIT_REF_DIS];
            end else if (paddr[15:2] == IDX_AUTOWAKE[13:0]) begin
                period_r <= pwdata[2:0];
                res_r    <= pwdata[BIT_RES];
            end else if (paddr[15:2] == IDX_TRIM_SEL[13:0]) begin
                trim_sel_r <= pwdata[3:0];
            end
        end
    end

    // Fuse readout and reference routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_r     <= 8'h00;
            vref_pad_r <= 1'b0;
        end else begin
            fuse_r     <= (trim_sel_r == TRIM_SEL_REF_MAG) ? reference_magnitude_trim : 8'h00; // [RL1]
            vref_pad_r <= ref_pad_r & !ref_dis_r;         // [RL3]
        end
    end

    // ****************************************************************
    // Watchdog and clock-calendar strobes
    // ****************************************************************
    // Kick needs byte-only write of all ones; unlock takes any byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_restart_r <= 1'b0;
            rtc_unlock_r <= 1'b0;
            rtc_val_r    <= 8'h00;
        end else begin
            wd_restart_r <= wr_en & (paddr[15:2] == IDX_WD_KICK[13:0]) & (pstrb == STRB_BYTE0)
                            & (pwdata[7:0] == KICK_VALUE); // [RL10]
            rtc_unlock_r <= wr_en & (paddr[15:2] == IDX_RTC_UNLOCK[13:0]); // [RL13]
            if (wr_en & (paddr[15:2] == IDX_RTC_UNLOCK[13:0])) begin
                rtc_val_r <= pwdata[7:0];
            end
        end
    end

    // Near-expiry flag: set wins over either clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            near_r <= 1'b0;
        end else if (wd_near_overflow) begin
            near_r <= 1'b1;                               // [RL9]
        end else if ((wr_en & (paddr[15:2] == IDX_NEAR_FLAG[13:0]) & !pwdata[BIT_NEAR])
                     | (wake_d_r & !wake_r)) begin
            near_r <= 1'b0;                               // [RL9]
        end
    end

    // Expired status lives on the nonvolatile reset only
    always_ff @(posedge pclk or negedge nv_rstn) begin
        if (!nv_rstn) begin
            expired_r <= 1'b0;
        end else if (wd_overflow) begin
            expired_r <= 1'b1;                            // [RL11]
        end else if (reset_pin_high
                     | (wr_en & (paddr[15:2] == IDX_WD_STATUS[13:0]) & !pwdata[BIT_EXPIRED])) begin
            expired_r <= 1'b0;                            // [RL12]
        end
    end

    // ****************************************************************
    // Autowake timer
    // ****************************************************************
    // Arm, hold in high power, count units in low power, then wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aw_r     <= AW_IDLE;
            remain_r <= 8'h00;
            pre_r    <= 27'h0;
            hp_d_r   <= 1'b0;
            wake_r   <= 1'b0;
            wake_d_r <= 1'b0;
        end else begin
            hp_d_r   <= hp;
            wake_d_r <= wake_r;
            case (aw_r)
                AW_IDLE: begin
                    wake_r <= 1'b0;
                    pre_r  <= 27'h0;
                    if (arm_wr) begin
                        aw_r     <= AW_ARMED;             // [RL4]
                        remain_r <= load_nxt;             // [RL4]
                    end
                end
                AW_ARMED: begin
                    pre_r <= 27'h0;
                    if (arm_wr) begin
                        remain_r <= load_nxt;             // [RL4]
                    end else if (hp & !hp_d_r) begin
                        aw_r <= AW_IDLE;                  // [RL5]
                    end else if (!hp & lp) begin
                        aw_r <= AW_RUN;
                    end
                end
                AW_RUN: begin
                    if (hp) begin
                        aw_r  <= AW_IDLE;                 // [RL5]
                        pre_r <= 27'h0;
                    end else if (remain_r == 8'h00) begin
                        aw_r   <= AW_WAKE;                // [RL16]
                        wake_r <= 1'b1;
                    end else if (unit_tick) begin
                        pre_r    <= 27'h0;
                        remain_r <= remain_r - 8'h01;
                    end else begin
                        pre_r <= pre_r + 27'h1;
                    end
                end
                AW_WAKE: begin
                    if (hp) begin
                        aw_r   <= AW_IDLE;                // [RL5]
                        wake_r <= 1'b0;
                    end
                end
                default: begin
                    aw_r <= AW_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Flash erase check
    // ****************************************************************
    // Refuse page erase inside a locked region
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_r   <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            refused_r <= erase.req & ((boot_lock_r & boot_hit) | (code_lock_r & code_hit)); // [RL14] [RL15]
            grant_r   <= erase.req & !((boot_lock_r & boot_hit) | (code_lock_r & code_hit));
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign fuse_readout     = fuse_r;
    assign vref_pad_en      = vref_pad_r;
    assign vref_disable     = ref_dis_r;
    assign wd_restart       = wd_restart_r;
    assign rtc_unlock       = rtc_unlock_r;
    assign rtc_unlock_value = rtc_val_r;
    assign wake_req         = wake_r;
    assign erase_grant      = grant_r;
    assign erase_refused    = refused_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_trim_select_out: assert property ($past(trim_sel_r) == TRIM_SEL_REF_MAG |-> // [RL1]
        fuse_readout == $past(reference_magnitude_trim)) else $error("Trim readout wrong");
    a_revision_read: assert property (acc_done & !pwrite & (paddr[15:2] == IDX_REVISION2[13:0]) // [RL2]
        |-> prdata[7:0] == REVISION) else $error("Revision read wrong");
    a_vref_route: assert property (ref_dis_r ##1 ref_dis_r |-> !vref_pad_en) // [RL3]
        else $error("Reference routed while disabled");
    a_arm_load: assert property (arm_wr & !res_r & (aw_r == AW_IDLE) |=> // [RL4]
        (aw_r == AW_ARMED) && (remain_r == {5'h00, $past(period_r)})) else $error("Arm load wrong");
    a_hold_disarm: assert property ((aw_r == AW_RUN) & hp |=> aw_r == AW_IDLE) // [RL5]
        else $error("Timer not disarmed");
    a_minute_load: assert property (arm_wr & res_r |=> remain_r == 8'($past(period_r) * 24)) // [RL8]
        else $error("Minute unit wrong");
    a_near_set: assert property (wd_near_overflow |=> near_r) else $error("Near flag not set"); // [RL9]
    a_kick_pulse: assert property (wr_en & (paddr[15:2] == IDX_WD_KICK[13:0]) & (pstrb == STRB_BYTE0) // [RL10]
        & (pwdata[7:0] == KICK_VALUE) |=> wd_restart ##1 !wd_restart) else $error("Kick pulse wrong");
    a_expired_clear: assert property (disable iff (!nv_rstn) reset_pin_high & !wd_overflow // [RL12]
        |=> !expired_r) else $error("Expired not cleared");
    a_expired_set: assert property (disable iff (!nv_rstn) wd_overflow |=> expired_r) // [RL11]
        else $error("Expired not set");
    a_erase_boot: assert property (erase.req & boot_lock_r & boot_hit |=> erase_refused & !erase_grant) // [RL14]
        else $error("Boot erase not refused");
    a_erase_code: assert property (erase.req & code_lock_r & code_hit |=> erase_refused) // [RL15]
        else $error("Code erase not refused");
    a_wake_zero: assert property ((aw_r == AW_RUN) & !hp & (remain_r == 8'h00) |=> wake_req) // [RL16]
        else $error("Wake not raised");
    a_apb_wait: assert property (psel & penable & !pready |=> pready) else $error("No ready");

    c_wake: cover property ((aw_r == AW_RUN) ##1 (aw_r == AW_WAKE));
    c_kick: cover property (wd_restart);
    c_refuse: cover property (erase_refused);
    c_near_clear: cover property (near_r ##1 !near_r);
endmodule : swwr_regs

//--- pkg/swwr_pkg.sv
package swwr_pkg;
    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [15:0] IDX_ERASE_LOCK  = 16'h00B2;
    localparam logic [15:0] IDX_WD_KICK     = 16'h00F8;
    localparam logic [15:0] IDX_WD_STATUS   = 16'h2002;
    localparam logic [15:0] IDX_VREF_CTRL   = 16'h2004;
    localparam logic [15:0] IDX_REVISION    = 16'h2006;
    localparam logic [15:0] IDX_RTC_UNLOCK  = 16'h201F;
    localparam logic [15:0] IDX_AUTOWAKE    = 16'h20A9;
    localparam logic [15:0] IDX_NEAR_FLAG   = 16'h20B1;
    localparam logic [15:0] IDX_REVISION2   = 16'h20C8;
    localparam logic [15:0] IDX_TRIM_SEL    = 16'h20FD;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_BOOT_LOCK = 5;
    localparam int BIT_CODE_LOCK = 4;
    localparam int BIT_KICK      = 7;
    localparam int BIT_EXPIRED   = 2;
    localparam int BIT_REF_PAD   = 7;
    localparam int BIT_REF_DIS   = 3;
    localparam int BIT_ARM       = 7;
    localparam int BIT_RES       = 3;
    localparam int BIT_NEAR      = 0;
    // ****************************************************************
    // Values and reset values
    // ****************************************************************
    localparam logic [7:0]  KICK_VALUE       = 8'hFF;
    localparam logic [3:0]  TRIM_SEL_REF_MAG = 4'h1;
    localparam logic [2:0]  PERIOD_RESET     = 3'h1;
    localparam logic [3:0]  TRIM_SEL_RESET   = 4'h0;
    localparam logic [7:0]  REVISION_DEFAULT = 8'h5A;  // Arbitrary value
    localparam logic [3:0]  STRB_BYTE0       = 4'h1;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_KHZ       = 50000;
    localparam int WAKE_UNIT_MS  = 2500;
    localparam int MINUTE_MS     = 60000;
    localparam int WAKE_UNIT_CYC = WAKE_UNIT_MS * CLK_KHZ;
    localparam logic [7:0] MINUTE_TICKS = 8'(MINUTE_MS / WAKE_UNIT_MS);
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        AW_IDLE  = 4'b0001,
        AW_ARMED = 4'b0010,
        AW_RUN   = 4'b0100,
        AW_WAKE  = 4'b1000
    } swwr_aw_e;
    typedef struct packed {
        logic full_power;
        logic brownout;
        logic sleep;
        logic display_only;
    } swwr_mode_s;
    typedef struct packed {
        logic        req;
        logic [17:0] addr;
    } swwr_erase_s;
endpackage : swwr_pkg
